// >>> design/apcr_consts.svh
// Constants for the converter power control register bank.
`ifndef APCR_CONSTS_SVH
`define APCR_CONSTS_SVH
`define APCR_PWR_ADDR 32'h4000F004
`define APCR_CFG_ADDR 32'h4000F404
`define APCR_ADDR_LSB_MASK 32'h00000FFF
`define APCR_PWR_RESET 32'h000A0022
`define APCR_PWR_MASK 32'h001FFFB3
`define APCR_CFG_RESET 32'h31888C82
`define APCR_BIT_FAST_OFF 20
`define APCR_BIT_SLOW_EN 19
`define APCR_BIT_BGR 18
`define APCR_BIT_RST_OFF 17
`define APCR_BIT_CONV_EN 16
`define APCR_BIT_FUSE 7
`define APCR_BIAS_HI 31
`define APCR_BIAS_LO 30
`define APCR_TRIM_HI 29
`define APCR_TRIM_LO 28
`define APCR_CHN_HI 27
`define APCR_CHN_LO 25
`define APCR_BIT_SINGLE 24
`define APCR_RESP_OKAY 2'h0
`define APCR_RESP_SLVERR 2'h2
`endif

// >>> design/apcr_pkg.sv
// Types for the converter power control register bank.
package apcr_pkg;
   typedef enum logic [1:0] {
      APCR_BIAS_4UA = 2'h0,
      APCR_BIAS_8UA = 2'h1,
      APCR_BIAS_20UA = 2'h2,
      APCR_BIAS_24UA = 2'h3
   } apcr_bias_type;
   typedef enum logic [2:0] {
      APCR_WR_IDLE = 3'h1,
      APCR_WR_RESP = 3'h2,
      APCR_WR_HOLD = 3'h4
   } apcr_wstate_type;
endpackage

// >>> design/apcr_regs.sv
// AXI4-Lite register bank for the converter power and analog configuration words.
`timescale 1ns/1ps
`include "apcr_consts.svh"
module apcr_regs import apcr_pkg::*; (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [31:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [31:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic BANDGAP_REF_ENABLE_O,
   output logic CONVERTER_RESET_ENGINE_OFF_O,
   output logic CONVERTER_CONVERSION_ENABLE_O,
   output logic FUSE_BANK_POWER_ENABLE_O,
   output logic FAST_OSC_FORCE_OFF_O,
   output logic SLOW_OSC_ENABLE_O,
   output logic [31:0] PWR_CTRL_WORD_O,
   output logic [1:0] COMPARATOR_BIAS_SELECT_O,
   output logic [1:0] TRIM_CODE_O,
   output logic [2:0] INPUT_CHANNEL_SELECT_O,
   output logic SINGLE_OR_SCAN_SELECT_O,
   output logic [7:0] INPUT_ONEHOT_O,
   output logic [3:0] SCAN_CHANNELS_O,
   output logic [23:0] ANALOG_TUNE_O
);
   localparam logic [31:0] PWR_RST = `APCR_PWR_RESET;
   localparam logic [31:0] PWR_MSK = `APCR_PWR_MASK;
   localparam logic [31:0] CFG_RST = `APCR_CFG_RESET;
   localparam logic [31:0] ADDR_MSK = `APCR_ADDR_LSB_MASK;
   localparam logic [31:0] PWR_ADR = `APCR_PWR_ADDR;
   localparam logic [31:0] CFG_ADR = `APCR_CFG_ADDR;

   apcr_wstate_type wst_r;
   apcr_wstate_type wst_nxt;
   logic aw_got_r;
   logic aw_got_nxt;
   logic w_got_r;
   logic w_got_nxt;
   logic [31:0] awaddr_r;
   logic [31:0] awaddr_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0] wstrb_r;
   logic [3:0] wstrb_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;
   logic [31:0] pwr_q;
   logic [31:0] cfg_q;
   logic [31:0] out_pwr_r;
   logic [31:0] out_cfg_r;
   logic [7:0] onehot_r;
   logic [7:0] onehot_nxt;
   logic [3:0] scan_r;
   logic [3:0] scan_nxt;
   logic do_write;
   logic hit_pwr_w;
   logic hit_cfg_w;
   logic hit_pwr_r;
   logic hit_cfg_r;
   logic ar_take;

   // Only the low address bits are decoded against each register's page offset.
   assign hit_pwr_w = ((awaddr_r & ADDR_MSK) == (PWR_ADR & ADDR_MSK));
   assign hit_cfg_w = ((awaddr_r & ADDR_MSK) == (CFG_ADR & ADDR_MSK));
   assign hit_pwr_r = ((ARADDR_I & ADDR_MSK) == (PWR_ADR & ADDR_MSK));
   assign hit_cfg_r = ((ARADDR_I & ADDR_MSK) == (CFG_ADR & ADDR_MSK));
   assign do_write = (wst_r == APCR_WR_IDLE) && aw_got_r && w_got_r;

   assign AWREADY_O = (wst_r == APCR_WR_IDLE) && !aw_got_r;
   assign WREADY_O = (wst_r == APCR_WR_IDLE) && !w_got_r;
   assign BVALID_O = (wst_r == APCR_WR_RESP);
   assign BRESP_O = bresp_r;
   assign ARREADY_O = !rvalid_r;
   assign ar_take = ARVALID_I && !rvalid_r;
   assign RVALID_O = rvalid_r;
   assign RDATA_O = rdata_r;
   assign RRESP_O = rresp_r;

   always_comb begin
      wst_nxt = wst_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bresp_nxt = bresp_r;
      case (wst_r)
         APCR_WR_IDLE: begin
            if (AWVALID_I && !aw_got_r) begin
               aw_got_nxt = 1'b1;
               awaddr_nxt = AWADDR_I;
            end
            if (WVALID_I && !w_got_r) begin
               w_got_nxt = 1'b1;
               wdata_nxt = WDATA_I;
               wstrb_nxt = WSTRB_I;
            end
            if (do_write) begin
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               bresp_nxt = (hit_pwr_w || hit_cfg_w) ? `APCR_RESP_OKAY : `APCR_RESP_SLVERR;
               wst_nxt = APCR_WR_RESP;
            end
         end
         APCR_WR_RESP: begin
            if (BREADY_I) begin
               wst_nxt = APCR_WR_IDLE;
            end
         end
         default: begin
            wst_nxt = APCR_WR_IDLE;
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         wst_r <= APCR_WR_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 32'h00000000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bresp_r <= 2'h0;
      end else begin
         wst_r <= wst_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // Unimplemented power bits are masked out of every write and read back as zero.
   apcr_word_reg #(
      .RESET_VAL(PWR_RST),
      .WR_MASK(PWR_MSK)
   ) u_pwr (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .we_i(do_write && hit_pwr_w),
      .wdata_i(wdata_r),
      .wstrb_i(wstrb_r),
      .q_o(pwr_q)
   );

   apcr_word_reg #(
      .RESET_VAL(CFG_RST),
      .WR_MASK(32'hFFFFFFFF)
   ) u_cfg (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .we_i(do_write && hit_cfg_w),
      .wdata_i(wdata_r),
      .wstrb_i(wstrb_r),
      .q_o(cfg_q)
   );

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && RREADY_I) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `APCR_RESP_OKAY;
         if (hit_pwr_r) begin
            rdata_nxt = pwr_q & PWR_MSK;
         end else if (hit_cfg_r) begin
            rdata_nxt = cfg_q;
         end else begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = `APCR_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Input decode: single mode lights the selected input, scan mode lights a bank of four.
   always_comb begin
      onehot_nxt = 8'h00;
      scan_nxt = 4'h0;
      onehot_nxt[cfg_q[`APCR_CHN_HI:`APCR_CHN_LO]] = 1'b1;
      if (!cfg_q[`APCR_BIT_SINGLE]) begin
         scan_nxt = 4'hF;
         if (cfg_q[`APCR_CHN_HI]) begin
            onehot_nxt = 8'hF0;
         end else begin
            onehot_nxt = 8'h0F;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         out_pwr_r <= PWR_RST;
         out_cfg_r <= CFG_RST;
         onehot_r <= 8'h01;
         scan_r <= 4'h0;
      end else begin
         out_pwr_r <= pwr_q & PWR_MSK;
         out_cfg_r <= cfg_q;
         onehot_r <= onehot_nxt;
         scan_r <= scan_nxt;
      end
   end

   assign BANDGAP_REF_ENABLE_O = out_pwr_r[`APCR_BIT_BGR];
   assign CONVERTER_RESET_ENGINE_OFF_O = out_pwr_r[`APCR_BIT_RST_OFF];
   assign CONVERTER_CONVERSION_ENABLE_O = out_pwr_r[`APCR_BIT_CONV_EN];
   assign FUSE_BANK_POWER_ENABLE_O = out_pwr_r[`APCR_BIT_FUSE];
   assign FAST_OSC_FORCE_OFF_O = out_pwr_r[`APCR_BIT_FAST_OFF];
   assign SLOW_OSC_ENABLE_O = out_pwr_r[`APCR_BIT_SLOW_EN];
   assign PWR_CTRL_WORD_O = out_pwr_r;
   assign COMPARATOR_BIAS_SELECT_O = out_cfg_r[`APCR_BIAS_HI:`APCR_BIAS_LO];
   assign TRIM_CODE_O = out_cfg_r[`APCR_TRIM_HI:`APCR_TRIM_LO];
   assign INPUT_CHANNEL_SELECT_O = out_cfg_r[`APCR_CHN_HI:`APCR_CHN_LO];
   assign SINGLE_OR_SCAN_SELECT_O = out_cfg_r[`APCR_BIT_SINGLE];
   assign INPUT_ONEHOT_O = onehot_r;
   assign SCAN_CHANNELS_O = scan_r;
   assign ANALOG_TUNE_O = out_cfg_r[23:0];
endmodule

// >>> design/apcr_word_reg.sv
// One 32-bit control word with a writable mask and byte strobes.
`timescale 1ns/1ps
module apcr_word_reg #(
   parameter logic [31:0] RESET_VAL = 32'h00000000,
   parameter logic [31:0] WR_MASK = 32'hFFFFFFFF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   output logic [31:0] q_o
);
   logic [31:0] q_r;
   logic [31:0] q_nxt;
   logic [31:0] lane_mask;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{wstrb_i[g]}};
      end
   endgenerate

   always_comb begin
      q_nxt = q_r;
      if (we_i) begin
         q_nxt = ((q_r & ~(lane_mask & WR_MASK)) | (wdata_i & lane_mask & WR_MASK));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= RESET_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule

// >>> test/apcr_regs_properties.sv
// Assertion checker for the converter power control register bank.
`timescale 1ns/1ps
module apcr_regs_chk (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic BVALID_O,
   input wire logic [31:0] PWR_CTRL_WORD_O,
   input wire logic BANDGAP_REF_ENABLE_O,
   input wire logic CONVERTER_RESET_ENGINE_OFF_O,
   input wire logic CONVERTER_CONVERSION_ENABLE_O,
   input wire logic [2:0] INPUT_CHANNEL_SELECT_O,
   input wire logic SINGLE_OR_SCAN_SELECT_O,
   input wire logic [7:0] INPUT_ONEHOT_O,
   input wire logic [3:0] SCAN_CHANNELS_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   // Outputs are settled two cycles after a write response rises.
   sequence settled_s;
      $rose(BVALID_O) ##2 1'b1;
   endsequence
   pwr_reset_a: assert property (RST_I ##1 RST_I |=> PWR_CTRL_WORD_O == 32'h000A0022)
      else $error("power word reset value wrong");
   onehot_reset_a: assert property (RST_I ##1 RST_I |=> INPUT_ONEHOT_O == 8'h01 && SCAN_CHANNELS_O == 4'h0)
      else $error("input select reset wrong");
   unimpl_zero_a: assert property (disable iff (RST_I) (PWR_CTRL_WORD_O & 32'hFFE0004C) == 32'h0)
      else $error("unimplemented power bit set");
   // A control level may only move one cycle after a write response has risen.
   bgr_bit_a: assert property (disable iff (RST_I) $changed(BANDGAP_REF_ENABLE_O) |->
      $past(BVALID_O) && !$past(BVALID_O, 2)) else $error("band-gap enable moved without a write");
   engine_bit_a: assert property (disable iff (RST_I) $changed(CONVERTER_RESET_ENGINE_OFF_O) |->
      $past(BVALID_O) && !$past(BVALID_O, 2)) else $error("reset engine moved without a write");
   conv_bit_a: assert property (disable iff (RST_I) $changed(CONVERTER_CONVERSION_ENABLE_O) |->
      $past(BVALID_O) && !$past(BVALID_O, 2)) else $error("conversion enable moved without a write");
   single_sel_a: assert property (disable iff (RST_I) settled_s ##0 SINGLE_OR_SCAN_SELECT_O |->
      INPUT_ONEHOT_O == 8'h01 << INPUT_CHANNEL_SELECT_O) else $error("single input select wrong");
   scan_sel_a: assert property (disable iff (RST_I) settled_s ##0 !SINGLE_OR_SCAN_SELECT_O |->
      SCAN_CHANNELS_O == 4'hF && INPUT_ONEHOT_O == (INPUT_CHANNEL_SELECT_O[2] ? 8'hF0 : 8'h0F))
      else $error("scan input select wrong");
   cover property (settled_s ##0 !SINGLE_OR_SCAN_SELECT_O);
   cover property (settled_s ##0 BANDGAP_REF_ENABLE_O);
   cover property (settled_s ##0 !CONVERTER_RESET_ENGINE_OFF_O);
endmodule
bind apcr_regs apcr_regs_chk apcr_regs_chk_inst (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .BVALID_O(BVALID_O),
   .PWR_CTRL_WORD_O(PWR_CTRL_WORD_O), .BANDGAP_REF_ENABLE_O(BANDGAP_REF_ENABLE_O),
   .CONVERTER_RESET_ENGINE_OFF_O(CONVERTER_RESET_ENGINE_OFF_O),
   .CONVERTER_CONVERSION_ENABLE_O(CONVERTER_CONVERSION_ENABLE_O), .INPUT_CHANNEL_SELECT_O(INPUT_CHANNEL_SELECT_O),
   .SINGLE_OR_SCAN_SELECT_O(SINGLE_OR_SCAN_SELECT_O), .INPUT_ONEHOT_O(INPUT_ONEHOT_O),
   .SCAN_CHANNELS_O(SCAN_CHANNELS_O));

// >>> test/tb.sv
// Self-checking bench for the converter power control register bank.
`timescale 1ns/1ps
`include "apcr_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic [31:0] awa = 0, wd = 0, ara = 0, rdw, pw;
   logic [3:0] ws = 0, scn;
   logic [1:0] br, rr, bias, trim;
   logic awr, wrr, bv, arr, rv, bgr, eng, conv, fuse, fst, slw, sng;
   logic [2:0] chn;
   logic [7:0] oh;
   logic [23:0] tune;
   logic [33:0] q[$], e;
   int miscompares = 0, compares = 0, cyc = 0;
   always #5 clk = ~clk;
   apcr_regs apcr_regs_inst (.SYS_CLK_I(clk), .RST_I(rst), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr),
      .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wrr), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bre),
      .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdw), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre),
      .BANDGAP_REF_ENABLE_O(bgr), .CONVERTER_RESET_ENGINE_OFF_O(eng), .CONVERTER_CONVERSION_ENABLE_O(conv),
      .FUSE_BANK_POWER_ENABLE_O(fuse), .FAST_OSC_FORCE_OFF_O(fst), .SLOW_OSC_ENABLE_O(slw), .PWR_CTRL_WORD_O(pw),
      .COMPARATOR_BIAS_SELECT_O(bias), .TRIM_CODE_O(trim), .INPUT_CHANNEL_SELECT_O(chn),
      .SINGLE_OR_SCAN_SELECT_O(sng), .INPUT_ONEHOT_O(oh), .SCAN_CHANNELS_O(scn), .ANALOG_TUNE_O(tune));
   task automatic give_verdict();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
      q.push_back({r, 32'h0});
      @(posedge clk);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrr) wv <= 1'b0;
      end while (!bv);
      bre <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [33:0] x);
      q.push_back(x);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      rre <= 1'b0;
   endtask
   // Responses are matched in order against the notes left by the bus tasks.
   always @(posedge clk) begin
      if (bv && bre) begin
         e = q.pop_front();
         `CHK(br, e[33:32])
      end
      if (rv && rre) begin
         e = q.pop_front();
         `CHK({rr, rdw}, e)
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      logic [31:0] v;
      void'($urandom(32'h6B4BDFAB));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      `CHK(pw, `APCR_PWR_RESET)
      `CHK({bias, trim, chn, sng, tune}, `APCR_CFG_RESET)
      `CHK({fst, slw, bgr, eng, conv, fuse}, 6'h14)
      rd(`APCR_PWR_ADDR, {2'h0, `APCR_PWR_RESET});
      rd(`APCR_CFG_ADDR, {2'h0, `APCR_CFG_RESET});
      wr(`APCR_PWR_ADDR, 32'hFFEFFFFF, 4'hF, `APCR_RESP_OKAY);
      rd(`APCR_PWR_ADDR, 34'h0000FFFB3);
      repeat (2) @(posedge clk);
      `CHK({bgr, conv, fuse, eng}, 4'hF)
      wr(`APCR_PWR_ADDR, 32'h00080000, 4'hF, `APCR_RESP_OKAY);
      repeat (2) @(posedge clk);
      `CHK({bgr, conv, fuse, eng}, 4'h0)
      wr(`APCR_PWR_ADDR, 32'hFFEDFFFF, 4'h4, `APCR_RESP_OKAY);
      rd(`APCR_PWR_ADDR, 34'h0000D0000);
      `CHK({bgr, conv, fuse, eng}, 4'hC)
      wr(32'h4000F008, 32'h0, 4'hF, `APCR_RESP_SLVERR);
      rd(32'h4000F00C, {`APCR_RESP_SLVERR, 32'h0});
      rd(`APCR_PWR_ADDR, 34'h0000D0000);
      // Every channel code is visited once in each mode; every bias code is visited four times.
      for (int i = 0; i < 16; i++) begin
         v = $urandom;
         v[31:30] = i[1:0];
         v[29:28] = 2'h3;
         v[27:24] = {i[2:0], i[3]};
         wr(`APCR_CFG_ADDR, v, 4'hF, `APCR_RESP_OKAY);
         rd(`APCR_CFG_ADDR, {2'h0, v});
         `CHK({bias, trim, chn, sng, tune}, v)
         `CHK({oh, scn}, v[24] ? {8'h01 << v[27:25], 4'h0} : {v[27] ? 8'hF0 : 8'h0F, 4'hF})
      end
      give_verdict();
   end
endmodule
